// *** src/clk_ctl_pkg.sv ***
// package: register map, field positions and reset values of the clock control
package clk_ctl_pkg;
    // ------------------------------------------------------------
    // register word addresses (byte address bits 3:2)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CLOCK_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_CLOCK_MODE3 = 4'h4;
    localparam logic [3:0] ADDR_POWER_MODE2 = 4'h8;
    localparam logic [3:0] ADDR_WDOG_CLOCK = 4'hc;
    localparam logic [3:0] ADDR_WDOG_START = 4'h0;
    localparam logic [3:0] ADDR_CONTROL = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_WDOG_COUNT = 4'hc;
    // upper address bit selects the second bank of four words
    localparam int BANK_BIT = 4;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BASE_SRC_POS = 0;       // clock_config_reg: 0 = pll
    localparam int MAIN_STOP_POS = 1;      // clock_config_reg
    localparam int OSC_EN_POS = 1;         // clock_mode_reg_three
    localparam int WDOG_SRC_POS = 3;       // power_mode_reg_two
    localparam int PRESC_SRC_POS = 4;      // watchdog_clock_reg
    localparam int WAIT_REQ_POS = 0;       // control register
    // status bit positions
    localparam int ST_PLL_POS = 0;
    localparam int ST_MAIN_POS = 1;
    localparam int ST_OCO_POS = 2;
    localparam int ST_OCO_RDY_POS = 3;
    localparam int ST_WAIT_POS = 4;
    localparam int ST_CPU_POS = 5;
    localparam int ST_PBUS_POS = 6;
    localparam int ST_WDOG_POS = 7;
    localparam int ST_SUB_POS = 8;
    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int REG_W = 8;
    localparam int ST_W = 9;
    localparam int WDOG_W = 16;
    localparam logic [7:0] CLOCK_CONFIG_RST = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [15:0] WDOG_RST = 16'h0000;
    localparam logic [15:0] WDOG_ONE = 16'h0001;
    // run-state of the on-chip oscillator
    typedef enum logic [1:0] {
        OCO_STOPPED = 2'b01,
        OCO_RUNNING = 2'b10
    } oco_state_t;
endpackage : clk_ctl_pkg

// *** src/wdog_counter.sv ***
// watchdog up counter, clocked by the gated enable from the clock control
`timescale 1ns/100ps
`default_nettype none
module wdog_counter (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic count_en,
    input wire logic restart,
    output logic [clk_ctl_pkg::WDOG_W-1:0] count
);
    logic [clk_ctl_pkg::WDOG_W-1:0] count_r;
    logic [clk_ctl_pkg::WDOG_W-1:0] count_nxt;

    // restart reloads; counting only when a clock reaches the counter
    assign count_nxt = restart ? clk_ctl_pkg::WDOG_RST
        : (count_en ? count_r + clk_ctl_pkg::WDOG_ONE : count_r);
    assign count = count_r;

    // ------------------------------------------------------------
    // counter register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            count_r <= clk_ctl_pkg::WDOG_RST;
        end else if (ce) begin
            count_r <= count_nxt;
        end
    end
endmodule : wdog_counter
`default_nettype wire

// *** src/clock_source_wait_control.sv ***
// clock source, on-chip oscillator start-up and wait-mode gating control
//
// Contract
// - pll keeps running while base source is pll, despite main stop bit
// - after reset, option select 1 and enable 0 hold oscillator stopped
// - oscillator starts when software writes 1 to any of three bits
// - oscillator clock usable at once, no stabilisation wait
// - wait mode stops base clock, hence cpu and peripheral bus clocks
// - wait mode halts cpu and, by default, the watchdog
// - watchdog keeps counting in wait if either source select bit is 1
// - main, sub, pll and on-chip oscillators keep running in wait
//
// single clock domain; ce low freezes every register, the bus too,
// so no answer comes while ce is low
// option pins are watched all the time; they must settle before
// reset is released for the start-up choice to count
//
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module clock_source_wait_control (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    // start-up option area levels
    input wire logic startup_osc_option_select,
    input wire logic startup_option_enable,
    // wakeup event ends wait mode
    input wire logic wake_event,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // clock enables toward the clock tree
    output logic pll_run,
    output logic main_osc_run,
    output logic sub_osc_run,
    output logic onchip_osc_run,
    output logic onchip_osc_ready,
    output logic cpu_clk_en,
    output logic pbus_clk_en,
    output logic wdog_clk_en,
    output logic wait_mode
);
    // ------------------------------------------------------------
    // option and wake pins pass a two-stage synchroniser
    // ------------------------------------------------------------
    logic opt_sel_s1_r;
    logic opt_sel_s2_r;
    logic opt_en_s1_r;
    logic opt_en_s2_r;
    logic wake_s1_r;
    logic wake_s2_r;

    // pins are asynchronous to mclk
    // no reset here: the chain flushes itself within two cycles
    always_ff @(posedge mclk) begin
        if (ce) begin
            opt_sel_s1_r <= startup_osc_option_select;
            opt_sel_s2_r <= opt_sel_s1_r;
            opt_en_s1_r <= startup_option_enable;
            opt_en_s2_r <= opt_en_s1_r;
            wake_s1_r <= wake_event;
            wake_s2_r <= wake_s1_r;
        end
    end

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // word map, writable registers in byte lane 0; status and count span lanes 0-1:
    //   bank 0 word 0  clock_config_reg: base source, main stop
    //   bank 0 word 1  clock_mode_reg_three: oscillator enable
    //   bank 0 word 2  power_mode_reg_two: watchdog source
    //   bank 0 word 3  watchdog_clock_reg: prescaler source
    //   bank 1 word 0  watchdog_start_reg: write restarts the count
    //   bank 1 word 1  control: wait request, reads back wait state
    //   bank 1 word 2  status: clock enables as the tree sees them
    //   bank 1 word 3  watchdog count, read only
    // every word of both banks decodes, so err only guards a later
    // decode change; writes without lane 0 are acked and dropped,
    // which keeps a byte-wise master from hanging
    logic [clk_ctl_pkg::REG_W-1:0] clock_config_reg_r;
    logic [clk_ctl_pkg::REG_W-1:0] clock_mode_reg_three_r;
    logic [clk_ctl_pkg::REG_W-1:0] power_mode_reg_two_r;
    logic [clk_ctl_pkg::REG_W-1:0] watchdog_clock_reg_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    wire req = wb_cyc_i && wb_stb_i && !ack_r;
    wire bank1 = wb_adr_i[clk_ctl_pkg::BANK_BIT];
    wire [3:0] word = {wb_adr_i[3:2], 2'b00};
    wire wr_lane0 = req && wb_we_i && wb_sel_i[0];
    wire hit_ccr = !bank1 && (word == clk_ctl_pkg::ADDR_CLOCK_CONFIG);
    wire hit_cm3 = !bank1 && (word == clk_ctl_pkg::ADDR_CLOCK_MODE3);
    wire hit_pm2 = !bank1 && (word == clk_ctl_pkg::ADDR_POWER_MODE2);
    wire hit_wdk = !bank1 && (word == clk_ctl_pkg::ADDR_WDOG_CLOCK);
    wire hit_wds = bank1 && (word == clk_ctl_pkg::ADDR_WDOG_START);
    wire hit_ctl = bank1 && (word == clk_ctl_pkg::ADDR_CONTROL);
    wire hit_sta = bank1 && (word == clk_ctl_pkg::ADDR_STATUS);
    wire hit_wdc = bank1 && (word == clk_ctl_pkg::ADDR_WDOG_COUNT);
    wire hit_any = hit_ccr || hit_cm3 || hit_pm2 || hit_wdk || hit_wds
        || hit_ctl || hit_sta || hit_wdc;
    wire wr_ccr = wr_lane0 && hit_ccr;
    wire wr_cm3 = wr_lane0 && hit_cm3;
    wire wr_pm2 = wr_lane0 && hit_pm2;
    wire wr_wdk = wr_lane0 && hit_wdk;
    wire wr_wds = wr_lane0 && hit_wds;
    wire wr_ctl = wr_lane0 && hit_ctl;

    // ------------------------------------------------------------
    // software control registers
    // ------------------------------------------------------------
    // writes land only through lane 0; other lanes are dropped
    always_ff @(posedge mclk) begin
        if (reset) begin
            clock_config_reg_r <= clk_ctl_pkg::CLOCK_CONFIG_RST;
            clock_mode_reg_three_r <= clk_ctl_pkg::ZERO_BYTE;
            power_mode_reg_two_r <= clk_ctl_pkg::ZERO_BYTE;
            watchdog_clock_reg_r <= clk_ctl_pkg::ZERO_BYTE;
        end else if (ce) begin
            if (wr_ccr) clock_config_reg_r <= wb_dat_i[7:0];
            if (wr_cm3) clock_mode_reg_three_r <= wb_dat_i[7:0];
            if (wr_pm2) power_mode_reg_two_r <= wb_dat_i[7:0];
            if (wr_wdk) watchdog_clock_reg_r <= wb_dat_i[7:0];
        end
    end

    wire base_source_select =
        clock_config_reg_r[clk_ctl_pkg::BASE_SRC_POS];
    wire main_osc_stop_bit = clock_config_reg_r[clk_ctl_pkg::MAIN_STOP_POS];
    wire onchip_osc_enable_bit =
        clock_mode_reg_three_r[clk_ctl_pkg::OSC_EN_POS];
    wire watchdog_source_select =
        power_mode_reg_two_r[clk_ctl_pkg::WDOG_SRC_POS];
    wire prescaler_source_select =
        watchdog_clock_reg_r[clk_ctl_pkg::PRESC_SRC_POS];

    // ------------------------------------------------------------
    // on-chip oscillator start-up
    // ------------------------------------------------------------
    clk_ctl_pkg::oco_state_t oco_r;
    clk_ctl_pkg::oco_state_t oco_nxt;
    logic oco_opt_pending_r;
    // a write of 1 to any start bit releases the stopped oscillator
    wire start_write = (wr_cm3 && wb_dat_i[clk_ctl_pkg::OSC_EN_POS])
        || (wr_pm2 && wb_dat_i[clk_ctl_pkg::WDOG_SRC_POS])
        || (wr_wdk && wb_dat_i[clk_ctl_pkg::PRESC_SRC_POS]);
    wire opt_hold = opt_sel_s2_r && !opt_en_s2_r;

    // no stop path: once running, only a reset stops the oscillator,
    // since nothing may halt it while the watchdog could be using it
    // option levels are only trusted once synchronised after release
    always_comb begin
        oco_nxt = oco_r;
        case (oco_r)
            clk_ctl_pkg::OCO_STOPPED: begin
                if (start_write || (!oco_opt_pending_r && !opt_hold)) begin
                    oco_nxt = clk_ctl_pkg::OCO_RUNNING;
                end
            end
            clk_ctl_pkg::OCO_RUNNING: begin
                oco_nxt = clk_ctl_pkg::OCO_RUNNING;
            end
            default: begin
                oco_nxt = clk_ctl_pkg::OCO_STOPPED;
            end
        endcase
    end

    // reset always enters the stopped state; the strap is judged after
    always_ff @(posedge mclk) begin
        if (reset) begin
            oco_r <= clk_ctl_pkg::OCO_STOPPED;
            oco_opt_pending_r <= 1'b1;
        end else if (ce) begin
            oco_r <= oco_nxt;
            oco_opt_pending_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // wait mode: entered by control write, left on wakeup
    // ------------------------------------------------------------
    // wake wins over a same-cycle wait request, so a pending wake is
    // never lost; wake is a level and a blip under one cycle may be
    // missed by the synchroniser
    logic wait_r;
    always_ff @(posedge mclk) begin
        if (reset) begin
            wait_r <= 1'b0;
        end else if (ce) begin
            if (wake_s2_r) begin
                wait_r <= 1'b0;
            end else if (wr_ctl && wb_dat_i[clk_ctl_pkg::WAIT_REQ_POS]) begin
                wait_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // clock enables
    // ------------------------------------------------------------
    wire oco_on = (oco_r == clk_ctl_pkg::OCO_RUNNING);
    // pll held alive while it feeds the base clock; wait does not stop it
    // with another base source it simply follows the main stop bit
    wire pll_nxt = !main_osc_stop_bit || !base_source_select;
    wire wdog_oco = watchdog_source_select || prescaler_source_select;
    wire wdog_nxt = wait_r ? (wdog_oco && oco_on) : 1'b1;

    // enables are registered so the tree sees glitch-free levels
    always_ff @(posedge mclk) begin
        if (reset) begin
            pll_run <= 1'b0;
            main_osc_run <= 1'b0;
            onchip_osc_run <= 1'b0;
            onchip_osc_ready <= 1'b0;
            cpu_clk_en <= 1'b0;
            pbus_clk_en <= 1'b0;
            wdog_clk_en <= 1'b0;
            wait_mode <= 1'b0;
        end else if (ce) begin
            pll_run <= pll_nxt;
            main_osc_run <= !main_osc_stop_bit;
            onchip_osc_run <= oco_on;
            onchip_osc_ready <= oco_on;
            cpu_clk_en <= !wait_r;
            pbus_clk_en <= !wait_r;
            wdog_clk_en <= wdog_nxt;
            wait_mode <= wait_r;
        end
    end
    // sub oscillator has no stop control in this block, so it stays on
    assign sub_osc_run = 1'b1;

    // ------------------------------------------------------------
    // watchdog counter, restarted by a start-register write
    // ------------------------------------------------------------
    // the count runs from the gated enable, so a wait with neither
    // source bit set freezes it until the wake
    logic [clk_ctl_pkg::WDOG_W-1:0] wdog_count;
    wdog_counter u_wdog (
        .mclk(mclk),
        .reset(reset),
        .ce(ce),
        .count_en(wdog_clk_en),
        .restart(wr_wds),
        .count(wdog_count)
    );

    // ------------------------------------------------------------
    // read data and acknowledge
    // ------------------------------------------------------------
    wire [clk_ctl_pkg::ST_W-1:0] status_word = {sub_osc_run, wdog_clk_en,
        pbus_clk_en, cpu_clk_en, wait_mode, onchip_osc_ready,
        onchip_osc_run, main_osc_run, pll_run};

    // read lanes, each register zero-extended to the bus width
    wire [31:0] rd_ccr = {24'h00_0000, clock_config_reg_r};
    wire [31:0] rd_cm3 = {24'h00_0000, clock_mode_reg_three_r};
    wire [31:0] rd_pm2 = {24'h00_0000, power_mode_reg_two_r};
    wire [31:0] rd_wdk = {24'h00_0000, watchdog_clock_reg_r};
    wire [31:0] rd_ctl = {31'h0000_0000, wait_r};
    wire [31:0] rd_sta = {23'h00_0000, status_word};
    wire [31:0] rd_wdc = {16'h0000, wdog_count};

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (hit_ccr) rdata_nxt = rd_ccr;
        else if (hit_cm3) rdata_nxt = rd_cm3;
        else if (hit_pm2) rdata_nxt = rd_pm2;
        else if (hit_wdk) rdata_nxt = rd_wdk;
        else if (hit_ctl) rdata_nxt = rd_ctl;
        else if (hit_sta) rdata_nxt = rd_sta;
        else if (hit_wdc) rdata_nxt = rd_wdc;
    end

    // one wait state: answer one edge after the request is seen
    // ack and err never rise together; a held request is answered again every second edge
    logic err_r;
    always_ff @(posedge mclk) begin
        if (reset) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else if (ce) begin
            ack_r <= req && hit_any;
            err_r <= req && !hit_any;
            rdata_r <= rdata_nxt;
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;
    assign wb_dat_o = rdata_r;
endmodule : clock_source_wait_control
`default_nettype wire

// *** testbench/clock_source_wait_control_asserts.sv ***
// checker: clock source, oscillator start and wait gating relations
`timescale 1ns/100ps
`default_nettype none
module cswc_checker (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic pll_run,
    input wire logic main_osc_run,
    input wire logic sub_osc_run,
    input wire logic onchip_osc_run,
    input wire logic onchip_osc_ready,
    input wire logic cpu_clk_en,
    input wire logic pbus_clk_en,
    input wire logic wdog_clk_en,
    input wire logic wait_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // shadow {prescaler src, watchdog src, main stop, base src}
    logic [3:0] sh_r;
    logic [1:0] up_r;
    wire ok = (up_r == 2'h3);
    wire wr_low = wb_ack_o && wb_we_i && wb_sel_i[0];
    wire start_w = wr_low && ((wb_adr_i == 5'h04 && wb_dat_i[1])
        || (wb_adr_i == 5'h08 && wb_dat_i[3])
        || (wb_adr_i == 5'h0c && wb_dat_i[4]));
    // captured at the ack edge, so it lines up with the outputs
    always_ff @(posedge mclk) begin
        if (reset) begin
            sh_r <= 4'h0;
            up_r <= 2'h0;
        end else begin
            if (!ok) up_r <= up_r + 2'h1;
            if (wr_low && wb_adr_i == 5'h00) sh_r[1:0] <= wb_dat_i[1:0];
            if (wr_low && wb_adr_i == 5'h08) sh_r[2] <= wb_dat_i[3];
            if (wr_low && wb_adr_i == 5'h0c) sh_r[3] <= wb_dat_i[4];
        end
    end
    property p_ack;
        wb_cyc_i && wb_stb_i && ce && !wb_ack_o && !wb_err_o
            |=> wb_ack_o || wb_err_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus request not answered in one cycle");
    property p_pll_hold; ok && !sh_r[0] |-> pll_run; endproperty
    a_pll_hold: assert property (p_pll_hold)
        else $error("pll stopped while feeding base clock");
    property p_pll_drop;
        ok && sh_r[1:0] == 2'h3 |-> !pll_run && !main_osc_run;
    endproperty
    a_pll_drop: assert property (p_pll_drop)
        else $error("stop bit ignored with non-pll base");
    property p_oco_start; start_w |=> onchip_osc_run; endproperty
    a_oco_start: assert property (p_oco_start)
        else $error("oscillator did not start after write");
    property p_oco_ready; start_w |=> onchip_osc_ready; endproperty
    a_oco_ready: assert property (p_oco_ready)
        else $error("oscillator running but not ready");
    property p_wait_gate; wait_mode |-> !cpu_clk_en && !pbus_clk_en;
    endproperty
    a_wait_gate: assert property (p_wait_gate)
        else $error("cpu or bus clock running in wait");
    property p_wdog;
        wait_mode && $past(wait_mode)
            |-> wdog_clk_en == ((sh_r[2] || sh_r[3]) && onchip_osc_run);
    endproperty
    a_wdog: assert property (p_wdog)
        else $error("watchdog clock wrong in wait");
    property p_osc_wait;
        wait_mode && ok |-> sub_osc_run && main_osc_run == !sh_r[1]
            && pll_run == !(sh_r[1] && sh_r[0]);
    endproperty
    a_osc_wait: assert property (p_osc_wait)
        else $error("oscillator stopped by wait");
endmodule : cswc_checker
bind clock_source_wait_control cswc_checker chk (.mclk(mclk),
    .reset(reset), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .pll_run(pll_run), .main_osc_run(main_osc_run),
    .sub_osc_run(sub_osc_run), .onchip_osc_run(onchip_osc_run),
    .onchip_osc_ready(onchip_osc_ready), .cpu_clk_en(cpu_clk_en),
    .pbus_clk_en(pbus_clk_en), .wdog_clk_en(wdog_clk_en),
    .wait_mode(wait_mode));
`default_nettype wire

// *** testbench/tb_top.sv ***
// testbench: oscillator start, pll hold and wait gating over wishbone
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    fail_count++; $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end end
module tb_top;
    logic mclk = 1'b0, reset = 1'b1, opt_sel = 1'b0, opt_en = 1'b0;
    logic wake = 1'b0, req = 1'b0, we = 1'b0, ce = 1'b1;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h0, rdat, rdat_o;
    logic ack, err, rerr, pll, mainr, sub, oco, rdy, cpu, pbus, wdg, wt;
    logic [15:0] cnt;
    int fail_count = 0, comparisons = 0, cycles = 0;
    logic [4:0] st_adr [3] = '{5'h04, 5'h08, 5'h0c};
    logic [31:0] st_dat [3] = '{32'h02, 32'h08, 32'h10};
    logic [31:0] cfg_v [4] = '{32'h02, 32'h03, 32'h01, 32'h00};
    logic [1:0] cfg_e [4] = '{2'h2, 2'h0, 2'h3, 2'h3};
    clock_source_wait_control dut (.mclk(mclk), .reset(reset), .ce(ce),
        .startup_osc_option_select(opt_sel),
        .startup_option_enable(opt_en), .wake_event(wake),
        .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat_o),
        .wb_ack_o(ack), .wb_err_o(err), .pll_run(pll), .main_osc_run(mainr),
        .sub_osc_run(sub), .onchip_osc_run(oco), .onchip_osc_ready(rdy),
        .cpu_clk_en(cpu), .pbus_clk_en(pbus), .wdog_clk_en(wdg),
        .wait_mode(wt));
    always #50 mclk = ~mclk;
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    // whole run is under two hundred cycles; hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end
    // classic single cycle; answer sampled and request released at the
    // same rising edge, so the next call leaves one idle cycle
    task automatic bus(input logic [4:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge mclk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge mclk); while (ack !== 1'b1 && err !== 1'b1);
        rdat = rdat_o;
        rerr = err;
        req <= 1'b0;
    endtask : bus
    // option levels settle during the four reset cycles
    task automatic restart(input logic s, input logic e);
        @(posedge mclk);
        reset <= 1'b1;
        opt_sel <= s;
        opt_en <= e;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(negedge mclk);
    endtask : restart
    // wake level held well past the synchroniser
    task automatic wake_up();
        @(posedge mclk);
        wake <= 1'b1;
        repeat (6) @(posedge mclk);
        wake <= 1'b0;
        repeat (2) @(negedge mclk);
    endtask : wake_up
    initial begin
        restart(1'b0, 1'b0);
        `CHK("oco free start", 1'b1, oco)
        for (int k = 0; k < 3; k++) begin
            restart(1'b1, 1'b0);
            `CHK("oco held", 1'b0, oco)
            bus(st_adr[k], 1'b1, st_dat[k]);
            @(negedge mclk);
            `CHK("oco start ready", 2'h3, {oco, rdy})
        end
        bus(5'h10, 1'b1, 32'h0);
        for (int j = 0; j < 4; j++) begin
            bus(5'h00, 1'b1, cfg_v[j]);
            @(negedge mclk);
            `CHK("pll main", cfg_e[j], {pll, mainr})
        end
        for (int m = 0; m < 3; m++) begin
            bus(5'h08, 1'b1, {28'h0, m[0], 3'h0});
            bus(5'h0c, 1'b1, {27'h0, m[1], 4'h0});
            bus(5'h14, 1'b1, 32'h01);
            @(negedge mclk);
            `CHK("cpu pbus", 2'h0, {cpu, pbus})
            `CHK("wdog wait", (m != 0), wdg)
            `CHK("osc wait", 4'hf, {pll, mainr, sub, oco})
            bus(5'h18, 1'b0, 32'h0);
            `CHK("status", {1'b1, (m != 0), 7'h1f}, rdat[8:0])
            `CHK("status err", 1'b0, rerr)
            bus(5'h1c, 1'b0, 32'h0);
            cnt = rdat[15:0];
            bus(5'h1c, 1'b0, 32'h0);
            `CHK("wdog count", (m != 0), rdat[15:0] != cnt)
            // frozen clock enable: a wake pulse must not reach the block
            @(posedge mclk);
            ce <= 1'b0;
            wake <= 1'b1;
            repeat (6) @(posedge mclk);
            ce <= 1'b1;
            wake <= 1'b0;
            repeat (2) @(negedge mclk);
            `CHK("ce freeze", 2'h1, {cpu, wt})
            wake_up();
            `CHK("wait left", 2'h2, {cpu, wt})
        end
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
